// ===== bench/daq_adc_dac_host_port_bench.sv
// top bench: host and converter ends joined by the link interface
// assumes the daqhp package, interface and both design ends compiled
`timescale 1ns/1ps
module daq_adc_dac_host_port_bench;
   import daqhp_pkg::*;
   logic ref_clk;
   logic rst;
   logic clkEn;
   logic readStartMode;
   logic clearReq;
   logic reqValid;
   daqhp_cmd_e reqKind;
   daqhp_byte_t reqData;
   logic reqReady;
   logic rspValid;
   daqhp_byte_t rspData;
   logic convDone;
   daqhp_byte_t analogLevel;
   daqhp_byte_t dacCode;
   logic holdActive;
   daqhp_byte_t lastResult;
   logic retriggerSeen;
   int miscompares;
   int samplesChecked;

   daqhp_link_if link();

   daqhp_device daqhp_device_i (.ref_clk(ref_clk), .rst(rst),
      .clkEn(clkEn), .link(link), .analogLevel(analogLevel),
      .dacCode(dacCode), .holdActive(holdActive),
      .lastResult(lastResult), .retriggerSeen(retriggerSeen));
   daqhp_host daqhp_host_i (.ref_clk(ref_clk), .rst(rst), .clkEn(clkEn),
      .link(link), .readStartMode(readStartMode), .clearReq(clearReq),
      .reqValid(reqValid), .reqKind(reqKind), .reqData(reqData),
      .reqReady(reqReady), .rspValid(rspValid), .rspData(rspData),
      .convDone(convDone));
   daqhp_link_properties daqhp_link_properties_i (.ref_clk(ref_clk),
      .rst(rst), .csN(link.csN), .rdN(link.rdN),
      .sampleTriggerN(link.sampleTriggerN), .clearN(link.clearN),
      .busyN(link.busyN), .doneN(link.doneN), .devData(link.devData),
      .devDataOeN(link.devDataOeN));

   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end

   task finishTest;
      $display("checks %0d mismatches %0d", samplesChecked, miscompares);
      if (miscompares == 0 && samplesChecked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task check(input string what, input logic [7:0] seen,
              input logic [7:0] exp);
      samplesChecked++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // every wait is bounded; running out ends the run
   task automatic waitFor(ref logic sig, input logic val, input int lim);
      int n;
      n = 0;
      while (sig !== val && n < lim) begin
         @(negedge ref_clk);
         n++;
      end
      if (sig !== val) begin
         miscompares++;
         $display("CHECK FAILED wait expected %b seen %b", val, sig);
         finishTest();
      end
   endtask

   task send(input daqhp_cmd_e k, input daqhp_byte_t d);
      waitFor(reqReady, 1'b1, 300);
      @(posedge ref_clk);
      reqValid <= 1'b1;
      reqKind <= k;
      reqData <= d;
      @(posedge ref_clk);
      reqValid <= 1'b0;
      @(negedge ref_clk);
   endtask

   task readStartConv;
      @(posedge ref_clk);
      analogLevel <= 8'hC3;
      send(DAQHP_CMD_READ, 8'h00);
      waitFor(link.busyN, 1'b0, 60);
      waitFor(link.devDataOeN, 1'b0, 20);
      check("oldResult", link.parallelDataBus, 8'h00);
      waitFor(rspValid, 1'b1, 2000);
      check("rspData", rspData, 8'hC3);
   endtask

   task automatic dacWrites;
      daqhp_byte_t codes[3] = '{8'hFF, 8'h00, 8'h5A};
      daqhp_byte_t prev;
      prev = 8'h00;
      foreach (codes[i]) begin
         send(DAQHP_CMD_WRITE, codes[i]);
         waitFor(link.wrN, 1'b0, 20);
         check("dacHeld", dacCode, prev);
         check("devOe", link.devDataOeN, 1'b1);
         waitFor(reqReady, 1'b1, 100);
         check("dacCode", dacCode, codes[i]);
         prev = codes[i];
      end
   endtask

   // leaving read-start mode drops the trigger pin: a real start edge
   task modeSwitch;
      // the spare command code is taken and dropped: nothing moves
      send(daqhp_cmd_e'(2'b11), 8'h00);
      repeat (20) @(negedge ref_clk);
      check("dacIgnored", dacCode, 8'h5A);
      check("busyIgnored", link.busyN, 1'b1);
      @(posedge ref_clk);
      analogLevel <= 8'h11;
      readStartMode <= 1'b0;
      waitFor(link.busyN, 1'b0, 60);
      waitFor(link.busyN, 1'b1, 400);
      check("lastResult", lastResult, 8'h11);
   endtask

   task triggerConv;
      @(posedge ref_clk);
      analogLevel <= 8'h3C;
      send(DAQHP_CMD_TRIG, 8'h00);
      waitFor(link.busyN, 1'b0, 60);
      check("holdActive", holdActive, 1'b1);
      @(posedge ref_clk);
      analogLevel <= 8'hF0;
      clearReq <= 1'b1;
      waitFor(link.clearN, 1'b0, 5);
      check("dacCode", dacCode, 8'h00);
      check("doneN", link.doneN, 1'b1);
      @(posedge ref_clk);
      clearReq <= 1'b0;
      waitFor(link.busyN, 1'b1, 400);
      check("holdActive", holdActive, 1'b0);
      check("lastResult", lastResult, 8'h3C);
      check("dacCode", dacCode, 8'h00);
      waitFor(convDone, 1'b1, 10);
      check("convDone", convDone, 1'b1);
      send(DAQHP_CMD_READ, 8'h00);
      waitFor(rspValid, 1'b1, 300);
      check("rspData", rspData, 8'h3C);
      waitFor(link.doneN, 1'b1, 20);
      check("doneN", link.doneN, 1'b1);
      check("retrigger", retriggerSeen, 1'b0);
   endtask

   initial begin
      rst = 1'b1;
      clkEn = 1'b1;
      readStartMode = 1'b1;
      clearReq = 1'b0;
      reqValid = 1'b0;
      reqKind = DAQHP_CMD_WRITE;
      reqData = 8'h00;
      analogLevel = 8'h00;
      miscompares = 0;
      samplesChecked = 0;
      repeat (16) @(posedge ref_clk);
      rst <= 1'b0;
      @(negedge ref_clk);
      check("busyN", link.busyN, 1'b1);
      check("dacCode", dacCode, 8'h00);
      readStartConv();
      dacWrites();
      modeSwitch();
      triggerConv();
      finishTest();
   end
endmodule

// ===== bench/daqhp_link_properties.sv
// concurrent checks on the link between converter and bus host
// assumes the bench's ref_clk and synchronous active-high rst
`timescale 1ns/1ps
module daqhp_link_properties (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // link pins
   input wire logic csN,
   input wire logic rdN,
   input wire logic sampleTriggerN,
   input wire logic clearN,
   input wire logic busyN,
   input wire logic doneN,
   input wire logic [7:0] devData,
   input wire logic devDataOeN
);
   logic [8:0] lowCnt_ff;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   // busy-low length in ref cycles; a counter, as 200 cycles is too long
   // for a repetition
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         lowCnt_ff <= 9'h000;
      end else if (!busyN) begin
         lowCnt_ff <= lowCnt_ff + 9'h001;
      end else begin
         lowCnt_ff <= 9'h000;
      end
   end

   a_bus_idle_quiet: assert property (
      (csN && rdN) [*5] |-> devDataOeN)
      else $error("data bus driven outside a read");
   a_end_sets_done: assert property (
      $rose(busyN) && clearN |-> ##[0:1] !doneN)
      else $error("conversion end without done low");
   a_conv_min_len: assert property (
      $rose(busyN) |-> lowCnt_ff > 9'h0AA)
      else $error("conversion ended early");
   a_conv_max_len: assert property (
      !busyN |-> lowCnt_ff < 9'h0D2)
      else $error("conversion too long");
   a_done_release: assert property (
      $rose(doneN) |-> !clearN || csN || rdN)
      else $error("done released without read end or clear");
   a_old_result: assert property (
      !busyN && $past(busyN) == 1'b0 |-> $stable(devData))
      else $error("result latch changed during conversion");
   a_trig_start: assert property (
      $fell(sampleTriggerN) && busyN |-> ##[2:6] !busyN)
      else $error("trigger edge did not start conversion");
   a_read_start: assert property (
      $fell(rdN) && !csN && sampleTriggerN && busyN |-> ##[2:8] !busyN)
      else $error("read did not start conversion");
endmodule

// ===== verilog/daqhp_device.sv
// converter end of the port: adc start/busy/done handshake, track and
// hold control, result latch, dac holding register with clear
// assumes all link pins are asynchronous to ref_clk except clearN,
// which acts asynchronously on the dac register and the done flag
//
// What this block does, and what it expects of the host
// - hold on start, back to track after end
// - conversion clock may run freely, any duty
// - trigger-pin mode and read-start mode both supported
// - trigger falling edge starts conversion, holds at once
// - busy low for the whole conversion
// - rising select or read ends done flag
// - host keeps trigger low while reading, trigger mode
// - host never retriggers during a conversion
// - read-start mode: trigger high, select+read starts
// - host stalls its read while busy low
// - read-start conversion ends eight clocks later
// - old result on bus during conversion
// - dac loads on rising write or select edge
// - both strobes low: dac register unchanged
// - clear forces dac register zero asynchronously
// - dac code is unsigned, zero to 255
// - host avoids dac writes during conversion
// - adc result is natural binary
// - end of conversion latches result, done low
// - clear raises done, conversion keeps running
// - one bit per falling clock edge, msb first
`timescale 1ns/1ps
`include "daqhp_regs.svh"
module daqhp_device (
   // clock, reset, enable
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic clkEn,
   // link to the bus host
   daqhp_link_if.dev link,
   // converter side
   input wire daqhp_pkg::daqhp_byte_t analogLevel,
   output daqhp_pkg::daqhp_byte_t dacCode,
   output logic holdActive,
   output daqhp_pkg::daqhp_byte_t lastResult,
   output logic retriggerSeen
);
   import daqhp_pkg::*;

   localparam int SyncW = `DAQHP_DEV_SYNC_W;

   logic [SyncW-1:0] pinRaw;
   logic [SyncW-1:0] meta_ff;
   logic [SyncW-1:0] pin_ff;
   logic [SyncW-1:0] prev_ff;
   logic csS;
   logic rdS;
   logic wrS;
   logic stS;
   logic clkS;
   logic csPrev;
   logic rdPrev;
   logic wrPrev;
   logic stPrev;
   logic clkPrev;
   daqhp_byte_t dataPrev;
   logic readActive;
   logic readWas;
   logic readStart;
   logic trigStart;
   logic startReq;
   logic startConv;
   logic readEnd;
   logic dacLoad;
   logic clkFall;
   logic converting;
   logic resultStrobe;
   daqhp_byte_t sarResult;
   daqhp_byte_t outLatch_ff;
   daqhp_byte_t dac_ff;
   logic busyN_ff;
   logic doneN_ff;
   logic hold_ff;
   logic retrig_ff;

   assign pinRaw = {link.convClk, link.sampleTriggerN, link.csN,
                    link.rdN, link.wrN, link.parallelDataBus};

   // three flops on every input pin except clearN; logic reads the second and the third
   generate
      for (genvar i = 0; i < SyncW; i++) begin : g_sync
         always_ff @(posedge ref_clk) begin
            if (rst) begin
               meta_ff[i] <= 1'b1;
               pin_ff[i] <= 1'b1;
               prev_ff[i] <= 1'b1;
            end else if (clkEn) begin
               meta_ff[i] <= pinRaw[i];
               pin_ff[i] <= meta_ff[i];
               prev_ff[i] <= pin_ff[i];
            end
         end
      end
   endgenerate

   assign csS = pin_ff[`DAQHP_PIN_CS];
   assign rdS = pin_ff[`DAQHP_PIN_RD];
   assign wrS = pin_ff[`DAQHP_PIN_WR];
   assign stS = pin_ff[`DAQHP_PIN_ST];
   assign clkS = pin_ff[`DAQHP_PIN_CLK];
   assign csPrev = prev_ff[`DAQHP_PIN_CS];
   assign rdPrev = prev_ff[`DAQHP_PIN_RD];
   assign wrPrev = prev_ff[`DAQHP_PIN_WR];
   assign stPrev = prev_ff[`DAQHP_PIN_ST];
   assign clkPrev = prev_ff[`DAQHP_PIN_CLK];
   // data one sample back, still stable while the strobe was low
   assign dataPrev = prev_ff[7:0];

   // bus access decode
   assign readActive = !csS && !rdS;
   assign readWas = !csPrev && !rdPrev;
   assign readEnd = readWas && !readActive;

   // start sources: trigger edge ignores select, read start needs
   // the trigger pin parked high
   assign trigStart = !stS && stPrev;
   assign readStart = readActive && !readWas && stS;
   assign startReq = trigStart || readStart;
   // a second start during a conversion is dropped, not restarted
   assign startConv = startReq && !converting;

   // only edges count, so any high time of the free clock works
   assign clkFall = !clkS && clkPrev;

   // write edge: rising strobe while the other one was still low
   assign dacLoad = (wrS && !wrPrev && !csPrev) ||
                    (csS && !csPrev && !wrPrev);

   daqhp_sar u_sar (
      .ref_clk(ref_clk),
      .rst(rst),
      .clkEn(clkEn),
      .start(startConv),
      .stepEdge(clkFall),
      .sampleIn(analogLevel),
      .converting(converting),
      .resultStrobe(resultStrobe),
      .result(sarResult)
   );

   // track/hold follows the conversion: hold from the start edge
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         hold_ff <= 1'b0;
      end else if (clkEn) begin
         if (startConv) begin
            hold_ff <= 1'b1;
         end else if (resultStrobe) begin
            hold_ff <= 1'b0;
         end
      end
   end

   // busy goes low with the start and high with the result
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         busyN_ff <= 1'b1;
      end else if (clkEn) begin
         if (startConv) begin
            busyN_ff <= 1'b0;
         end else if (resultStrobe) begin
            busyN_ff <= 1'b1;
         end
      end
   end

   // result latch keeps the old value until the new one is final
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         outLatch_ff <= `DAQHP_RESULT_RST;
      end else if (clkEn && resultStrobe) begin
         outLatch_ff <= sarResult;
      end
   end

   // done flag: clear acts at once and leaves the sar alone; an end
   // of conversion in the same cycle as a read end wins
   always_ff @(posedge ref_clk or negedge link.clearN) begin
      if (!link.clearN) begin
         doneN_ff <= 1'b1;
      end else if (rst) begin
         doneN_ff <= 1'b1;
      end else if (clkEn) begin
         if (resultStrobe) begin
            doneN_ff <= 1'b0;
         end else if (readEnd) begin
            doneN_ff <= 1'b1;
         end
      end
   end

   // dac holding register; static strobe levels never load it
   always_ff @(posedge ref_clk or negedge link.clearN) begin
      if (!link.clearN) begin
         dac_ff <= `DAQHP_DAC_RST;
      end else if (rst) begin
         dac_ff <= `DAQHP_DAC_RST;
      end else if (clkEn && dacLoad) begin
         dac_ff <= dataPrev;
      end
   end

   // sticky note that the host broke the no-retrigger contract
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         retrig_ff <= 1'b0;
      end else if (clkEn && startReq && converting) begin
         retrig_ff <= 1'b1;
      end
   end

   assign link.busyN = busyN_ff;
   assign link.doneN = doneN_ff;
   assign link.devData = outLatch_ff;
   assign link.devDataOeN = !readActive;
   // unsigned code; analog out is code/256 of full scale
   assign dacCode = dac_ff;
   assign holdActive = hold_ff;
   assign lastResult = outLatch_ff;
   assign retriggerSeen = retrig_ff;
endmodule

// ===== verilog/daqhp_host.sv
// bus host end: makes the conversion clock, runs dac writes, trigger
// pulses and adc reads on the parallel pins, one command at a time
// assumes busyN, doneN and the bus are asynchronous to ref_clk
`timescale 1ns/1ps
`include "daqhp_regs.svh"
module daqhp_host (
   // clock, reset, enable
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic clkEn,
   // link to the converter
   daqhp_link_if.host link,
   // mode and clear
   input wire logic readStartMode,
   input wire logic clearReq,
   // command
   input wire logic reqValid,
   input wire daqhp_pkg::daqhp_cmd_e reqKind,
   input wire daqhp_pkg::daqhp_byte_t reqData,
   output logic reqReady,
   // answer
   output logic rspValid,
   output daqhp_pkg::daqhp_byte_t rspData,
   output logic convDone
);
   import daqhp_pkg::*;

   localparam int SyncW = `DAQHP_HOST_SYNC_W;

   logic [SyncW-1:0] pinRaw;
   logic [SyncW-1:0] meta_ff;
   logic [SyncW-1:0] pin_ff;
   daqhp_hstate_e state_ff;
   logic [4:0] cnt_ff;
   logic [4:0] div_ff;
   logic convClk_ff;
   logic csN_ff;
   logic rdN_ff;
   logic wrN_ff;
   logic stN_ff;
   logic clearN_ff;
   logic oeN_ff;
   daqhp_byte_t data_ff;
   logic rspValid_ff;
   daqhp_byte_t rsp_ff;
   logic busyS;
   logic strobeDone;
   logic turnDone;

   assign pinRaw = {link.busyN, link.doneN, link.parallelDataBus};

   generate
      for (genvar i = 0; i < SyncW; i++) begin : g_sync
         always_ff @(posedge ref_clk) begin
            if (rst) begin
               meta_ff[i] <= 1'b1;
               pin_ff[i] <= 1'b1;
            end else if (clkEn) begin
               meta_ff[i] <= pinRaw[i];
               pin_ff[i] <= meta_ff[i];
            end
         end
      end
   endgenerate

   assign busyS = pin_ff[`DAQHP_HPIN_BUSY];

   // free-running conversion clock, 48 % high time
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         div_ff <= 5'h0;
         convClk_ff <= 1'b0;
      end else if (clkEn) begin
         div_ff <= (div_ff == 5'(`DAQHP_CONV_DIV - 1)) ?
                   5'h0 : div_ff + 5'h1;
         convClk_ff <= (div_ff < 5'(`DAQHP_CONV_HIGH - 1)) ||
                       (div_ff == 5'(`DAQHP_CONV_DIV - 1));
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         clearN_ff <= 1'b1;
      end else if (clkEn) begin
         clearN_ff <= !clearReq;
      end
   end

   assign strobeDone = cnt_ff == 5'(`DAQHP_STROBE_CYC - 1);
   assign turnDone = cnt_ff >= 5'(`DAQHP_TURN_CYC - 1);

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state_ff <= DAQHP_H_IDLE;
         cnt_ff <= 5'h0;
         csN_ff <= 1'b1;
         rdN_ff <= 1'b1;
         wrN_ff <= 1'b1;
         stN_ff <= 1'b1;
         oeN_ff <= 1'b1;
         data_ff <= 8'h00;
         rspValid_ff <= 1'b0;
         rsp_ff <= 8'h00;
      end else if (clkEn) begin
         rspValid_ff <= 1'b0;
         cnt_ff <= cnt_ff + 5'h1;
         unique case (state_ff)
            DAQHP_H_IDLE: begin
               cnt_ff <= 5'h0;
               // trigger rests high for read start, low otherwise
               stN_ff <= readStartMode;
               if (reqValid) begin
                  unique case (reqKind)
                     DAQHP_CMD_WRITE: begin
                        data_ff <= reqData;
                        oeN_ff <= 1'b0;
                        csN_ff <= 1'b0;
                        wrN_ff <= 1'b0;
                        state_ff <= DAQHP_H_WRITE;
                     end
                     DAQHP_CMD_READ: begin
                        csN_ff <= 1'b0;
                        rdN_ff <= 1'b0;
                        state_ff <= DAQHP_H_RSETUP;
                     end
                     DAQHP_CMD_TRIG: begin
                        stN_ff <= 1'b1;
                        state_ff <= DAQHP_H_TRIG;
                     end
                     default: begin
                        state_ff <= DAQHP_H_IDLE;
                     end
                  endcase
               end
            end
            DAQHP_H_WRITE: begin
               if (strobeDone) begin
                  csN_ff <= 1'b1;
                  wrN_ff <= 1'b1;
                  cnt_ff <= 5'h0;
                  state_ff <= DAQHP_H_WREL;
               end
            end
            DAQHP_H_WREL: begin
               if (strobeDone) begin
                  oeN_ff <= 1'b1;
                  state_ff <= DAQHP_H_IDLE;
               end
            end
            DAQHP_H_TRIG: begin
               // falling edge after a high phase; stays low after in trigger mode, back high next cycle in read-start mode
               if (strobeDone) begin
                  stN_ff <= 1'b0;
                  state_ff <= DAQHP_H_IDLE;
               end
            end
            DAQHP_H_RSETUP: begin
               if (turnDone) begin
                  cnt_ff <= 5'h0;
                  state_ff <= DAQHP_H_RWAIT;
               end
            end
            DAQHP_H_RWAIT: begin
               // wait state of any length while busy is low
               cnt_ff <= 5'h0;
               if (busyS) begin
                  state_ff <= DAQHP_H_RSETTLE;
               end
            end
            DAQHP_H_RSETTLE: begin
               if (turnDone) begin
                  rsp_ff <= pin_ff[7:0];
                  rspValid_ff <= 1'b1;
                  csN_ff <= 1'b1;
                  rdN_ff <= 1'b1;
                  state_ff <= DAQHP_H_IDLE;
               end
            end
         endcase
      end
   end

   assign reqReady = clkEn && state_ff == DAQHP_H_IDLE;
   assign rspValid = rspValid_ff;
   assign rspData = rsp_ff;
   assign convDone = !pin_ff[`DAQHP_HPIN_DONE];
   assign link.csN = csN_ff;
   assign link.rdN = rdN_ff;
   assign link.wrN = wrN_ff;
   assign link.sampleTriggerN = stN_ff;
   assign link.clearN = clearN_ff;
   assign link.convClk = convClk_ff;
   assign link.hostData = data_ff;
   assign link.hostDataOeN = oeN_ff;
endmodule

// ===== verilog/daqhp_link_if.sv
// pins between the converter and its bus host
// the data bus is resolved here from the two low-active enables;
// with nobody driving it reads as all ones, like a pulled-up bus
`timescale 1ns/1ps
interface daqhp_link_if;
   logic csN;
   logic rdN;
   logic wrN;
   logic sampleTriggerN;
   logic clearN;
   logic convClk;
   logic busyN;
   logic doneN;
   logic [7:0] hostData;
   logic hostDataOeN;
   logic [7:0] devData;
   logic devDataOeN;
   logic [7:0] parallelDataBus;

   assign parallelDataBus = !hostDataOeN ? hostData :
                            (!devDataOeN ? devData : 8'hFF);

   modport dev (
      input csN, rdN, wrN, sampleTriggerN, clearN, convClk,
      input parallelDataBus,
      output busyN, doneN, devData, devDataOeN
   );

   modport host (
      output csN, rdN, wrN, sampleTriggerN, clearN, convClk,
      output hostData, hostDataOeN,
      input busyN, doneN, parallelDataBus
   );
endinterface

// ===== verilog/daqhp_pkg.sv
// shared types of the converter port
// assumes nothing beyond the timing header
package daqhp_pkg;

   typedef logic [7:0] daqhp_byte_t;

   typedef enum logic [1:0] {
      DAQHP_CMD_WRITE = 2'b00,
      DAQHP_CMD_READ = 2'b01,
      DAQHP_CMD_TRIG = 2'b10
   } daqhp_cmd_e;

   typedef enum logic [2:0] {
      DAQHP_H_IDLE = 3'b000,
      DAQHP_H_WRITE = 3'b001,
      DAQHP_H_WREL = 3'b010,
      DAQHP_H_TRIG = 3'b011,
      DAQHP_H_RSETUP = 3'b100,
      DAQHP_H_RWAIT = 3'b101,
      DAQHP_H_RSETTLE = 3'b110
   } daqhp_hstate_e;

endpackage

// ===== verilog/daqhp_regs.svh
// timing counts, pin positions and reset values of the converter port
// assumes ref_clk at 125 MHz; included by both ends and the sar module
`ifndef DAQHP_REGS_SVH
`define DAQHP_REGS_SVH

// clock periods in ns
`define DAQHP_REF_CLK_NS 8
`define DAQHP_CONV_CLK_NS 200

// conversion clock divider: 25 ref cycles, high for 12 of them (48 %)
`define DAQHP_CONV_DIV (`DAQHP_CONV_CLK_NS / `DAQHP_REF_CLK_NS)
`define DAQHP_CONV_HIGH (`DAQHP_CONV_DIV / 2)

// least strobe width and hold time on the bus, rounded up to cycles
`define DAQHP_STROBE_NS 80
`define DAQHP_STROBE_CYC \
   ((`DAQHP_STROBE_NS + `DAQHP_REF_CLK_NS - 1) / `DAQHP_REF_CLK_NS)

// round trip through both synchronisers before status is trusted
`define DAQHP_TURN_NS 48
`define DAQHP_TURN_CYC \
   ((`DAQHP_TURN_NS + `DAQHP_REF_CLK_NS - 1) / `DAQHP_REF_CLK_NS)

// least wait state the host must accept in read-start mode
`define DAQHP_WAIT_NS 2000

// approximation register
`define DAQHP_SAR_MSB 3'h7
`define DAQHP_SAR_FIRST 8'h80
`define DAQHP_SAR_RST 8'h00

// reset values
`define DAQHP_DAC_RST 8'h00
`define DAQHP_RESULT_RST 8'h00

// device pin synchroniser vector: data bus in bits 7..0
`define DAQHP_DEV_SYNC_W 13
`define DAQHP_PIN_WR 8
`define DAQHP_PIN_RD 9
`define DAQHP_PIN_CS 10
`define DAQHP_PIN_ST 11
`define DAQHP_PIN_CLK 12

// host pin synchroniser vector: data bus in bits 7..0
`define DAQHP_HOST_SYNC_W 10
`define DAQHP_HPIN_DONE 8
`define DAQHP_HPIN_BUSY 9

`endif

// ===== verilog/daqhp_sar.sv
// successive approximation engine: holds a sample, decides one bit
// per conversion clock falling edge, msb first
// assumes stepEdge is a one-cycle pulse on ref_clk
`timescale 1ns/1ps
`include "daqhp_regs.svh"
module daqhp_sar (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic clkEn,
   // control
   input wire logic start,
   input wire logic stepEdge,
   input wire daqhp_pkg::daqhp_byte_t sampleIn,
   // status and result
   output logic converting,
   output logic resultStrobe,
   output daqhp_pkg::daqhp_byte_t result
);
   import daqhp_pkg::*;

   daqhp_byte_t approximationRegister_ff;
   daqhp_byte_t hold_ff;
   logic [2:0] bitSel_ff;
   logic busy_ff;
   logic strobe_ff;
   daqhp_byte_t result_ff;
   daqhp_byte_t nxt_approx;

   // trial bit drops when the trial code is above the held sample
   always_comb begin
      nxt_approx = approximationRegister_ff;
      if (approximationRegister_ff > hold_ff) begin
         nxt_approx[bitSel_ff] = 1'b0;
      end
      if (bitSel_ff != 3'h0) begin
         nxt_approx[bitSel_ff - 3'h1] = 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         approximationRegister_ff <= `DAQHP_SAR_RST;
         hold_ff <= `DAQHP_SAR_RST;
         bitSel_ff <= `DAQHP_SAR_MSB;
         busy_ff <= 1'b0;
         strobe_ff <= 1'b0;
      end else if (clkEn) begin
         strobe_ff <= 1'b0;
         if (start && !busy_ff) begin
            hold_ff <= sampleIn;
            approximationRegister_ff <= `DAQHP_SAR_FIRST;
            bitSel_ff <= `DAQHP_SAR_MSB;
            busy_ff <= 1'b1;
         end else if (busy_ff && stepEdge) begin
            if (bitSel_ff == 3'h0) begin
               // register is cleared once the result has left it
               approximationRegister_ff <= `DAQHP_SAR_RST;
               busy_ff <= 1'b0;
               strobe_ff <= 1'b1;
            end else begin
               approximationRegister_ff <= nxt_approx;
               bitSel_ff <= bitSel_ff - 3'h1;
            end
         end
      end
   end

   // natural binary: largest code not above the held sample
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         result_ff <= `DAQHP_RESULT_RST;
      end else if (clkEn && busy_ff && stepEdge && bitSel_ff == 3'h0) begin
         result_ff <= nxt_approx;
      end
   end

   assign converting = busy_ff;
   assign resultStrobe = strobe_ff;
   assign result = result_ff;
endmodule
